// ==== dv/sfx_core_assertions.sv ====
// Checker for the stack frame op unit.
// Assumes it is bound to sfx_core and sees only its ports.
`timescale 1ns/1ps
module sfx_chk
(
  // Watched ports.
  input wire ref_clk,
  input wire resetn,
  input wire instr_valid,
  input wire [15:0] instr,
  input wire extension_enable_bit,
  input wire [20:0] return_stack_top,
  input wire [11:0] mem_raddr_q,
  input wire mem_we_q,
  input wire [11:0] mem_waddr_q,
  input wire [7:0] mem_wdata_q,
  input wire [11:0] indirect_pointer0_q,
  input wire [11:0] frame_pointer_q,
  input wire pc_load_q,
  input wire [20:0] pc_value_q,
  input wire busy_q
);
  // A word is only taken when enabled and not stalled.
  wire go = instr_valid && extension_enable_bit && !busy_q;
  // Indirect windows, at the latched move source and at the write address.
  wire src_win = (mem_raddr_q >= 12'hFDB && mem_raddr_q <= 12'hFDF) ||
    (mem_raddr_q >= 12'hFE3 && mem_raddr_q <= 12'hFE7) ||
    (mem_raddr_q >= 12'hFEB && mem_raddr_q <= 12'hFEF);
  wire dst_win = (mem_waddr_q >= 12'hFDB && mem_waddr_q <= 12'hFDF) ||
    (mem_waddr_q >= 12'hFE3 && mem_waddr_q <= 12'hFE7) ||
    (mem_waddr_q >= 12'hFEB && mem_waddr_q <= 12'hFEF);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  AST_PUSH_WR: assert property (go && instr[15:8] == 8'hFA |=> mem_we_q &&
    mem_waddr_q == $past(frame_pointer_q) && mem_wdata_q == $past(instr[7:0])) else $error("push");
  AST_PUSH_DEC: assert property (go && instr[15:8] == 8'hFA |=>
    frame_pointer_q == $past(frame_pointer_q) - 12'h001) else $error("push pointer");
  AST_SUB_PTR: assert property (go && instr[15:6] == 10'h3A4 |=>
    indirect_pointer0_q == $past(indirect_pointer0_q) - $past(instr[5:0])) else $error("sub");
  AST_RET: assert property (go && instr[15:6] == 10'h3A7 |=> pc_load_q && busy_q &&
    pc_value_q == $past(return_stack_top) && $stable(indirect_pointer0_q)) else $error("ret");
  AST_RET_FP: assert property (go && instr[15:6] == 10'h3A7 |=>
    frame_pointer_q == $past(frame_pointer_q) - $past(instr[5:0])) else $error("ret pointer");
  AST_RET_NOP: assert property (pc_load_q |=> !pc_load_q && !mem_we_q
    && $stable(frame_pointer_q)) else $error("second cycle");
  AST_OFF: assert property (!extension_enable_bit && !busy_q |=> !mem_we_q && !pc_load_q
    && $stable(frame_pointer_q)) else $error("disabled");
  AST_PROT: assert property (mem_we_q && $past(busy_q) |-> mem_waddr_q != 12'hFF9
    && mem_waddr_q < 12'hFFD) else $error("protected write");
  AST_MOVE_DST: assert property (mem_we_q && $past(busy_q) |-> !dst_win)
    else $error("move wrote an indirect register");
  AST_MOVE_ZERO: assert property (mem_we_q && $past(busy_q) && $past(src_win) |->
    mem_wdata_q == 8'h00) else $error("indirect source not read as zero");
  AST_MOVE_SRC: assert property (go && instr[15:7] == 9'h1D7 |=> busy_q &&
    mem_raddr_q == $past(frame_pointer_q) + $past(instr[6:0])) else $error("move source");
endmodule
bind sfx_core sfx_chk chk (.ref_clk, .resetn, .instr_valid, .instr, .extension_enable_bit,
  .return_stack_top, .mem_raddr_q, .mem_we_q, .mem_waddr_q, .mem_wdata_q,
  .indirect_pointer0_q, .frame_pointer_q, .pc_load_q, .pc_value_q, .busy_q);

// ==== dv/sfx_core_bench.sv ====
// Self-checking bench for the stack frame op unit.
// Assumes sfx_core; the data memory is modelled here.
`timescale 1ns/1ps
module sfx_core_bench;
  reg ref_clk = 1'b0;
  reg resetn = 1'b0;
  reg instr_valid = 1'b0;
  reg [15:0] instr = 16'h0000;
  reg extension_enable_bit = 1'b0;
  reg [20:0] return_stack_top = 21'h00000;
  wire [11:0] mem_raddr_q, mem_waddr_q, indirect_pointer0_q, indirect_pointer1_q;
  wire [11:0] frame_pointer_q;
  wire mem_we_q, pc_load_q, busy_q;
  wire [7:0] mem_wdata_q;
  wire [20:0] pc_value_q;
  reg [7:0] mem [0:4095];
  wire [7:0] mem_rdata = mem[mem_raddr_q];
  reg [11:0] fp, p0, p1, s, d;
  reg [7:0] k, e, x;
  integer bad_count = 0, checked = 0, i;
  sfx_core uut (.ref_clk, .resetn, .instr_valid, .instr, .extension_enable_bit,
    .return_stack_top, .mem_raddr_q, .mem_rdata, .mem_we_q, .mem_waddr_q, .mem_wdata_q,
    .indirect_pointer0_q, .indirect_pointer1_q, .frame_pointer_q, .pc_load_q,
    .pc_value_q, .busy_q);
  // Free-running clock.
  always #25 ref_clk = ~ref_clk;
  // Memory writes land one edge after the pulse.
  always @(posedge ref_clk)
    if (mem_we_q)
      mem[mem_waddr_q] <= mem_wdata_q;
  // Indirect windows read as zero and refuse writes.
  function ind(input [11:0] a);
    ind = (a >= 12'hFDB && a <= 12'hFDF) || (a >= 12'hFE3 && a <= 12'hFE7) ||
      (a >= 12'hFEB && a <= 12'hFEF);
  endfunction
  task chk(input [20:0] g, input [20:0] w);
    begin
      checked = checked + 1;
      if (g !== w)
      begin
        bad_count = bad_count + 1;
        $display("CHECK FAILED %0t got %h want %h", $time, g, w);
      end
    end
  endtask
  // Holds each word for one cycle; the second word follows at once.
  task send(input [15:0] w1, input [15:0] w2, input two);
    begin
      @(posedge ref_clk);
      instr <= w1;
      instr_valid <= 1'b1;
      if (two)
        @(posedge ref_clk) instr <= w2;
      @(posedge ref_clk);
      instr_valid <= 1'b0;
      #1;
    end
  endtask
  task test_done;
    begin
      $display("checks %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  // Main sequence.
  initial
  begin
    void'($urandom(18));
    for (i = 0; i < 4096; i = i + 1)
      mem[i] = $urandom;
    repeat (20) @(posedge ref_clk);
    resetn <= 1'b1;
    e = mem[0];
    send(16'hFA5A, 16'h0000, 0);
    @(posedge ref_clk);
    #1;
    chk(frame_pointer_q, 12'h000);
    chk(mem[0], e);
    $display("test disabled done");
    extension_enable_bit <= 1'b1;
    fp = 12'h000;
    p0 = 12'h000;
    p1 = 12'h000;
    for (i = 0; i < 4; i = i + 1)
    begin
      k = $urandom;
      send({8'hFA, k}, 16'h0000, 0);
      @(posedge ref_clk);
      #1;
      chk(mem[fp], k);
      fp = fp - 12'h001;
      chk(frame_pointer_q, fp);
    end
    return_stack_top <= $urandom;
    send(16'hE9DC, 16'h0000, 0);
    chk(pc_load_q, 1'b1);
    chk(pc_value_q, return_stack_top);
    fp = fp - 12'h01C;
    chk(frame_pointer_q, fp);
    @(posedge ref_clk);
    #1;
    chk(pc_load_q, 1'b0);
    chk(frame_pointer_q, fp);
    $display("test push and return done");
    // Frame pointer now sits at FE0h, so offsets reach two indirect windows,
    // the protected top bytes and, by wrapping, the bottom of memory.
    for (i = 0; i < 24; i = i + 1)
    begin
      k = (i == 0) ? 8'h0B : $urandom;
      e = (i == 1) ? 8'h07 : (i == 2) ? 8'h1F : (i == 3) ? 8'h19 : $urandom;
      s = fp + k[6:0];
      d = fp + e[6:0];
      x = (ind(d) || d == 12'hFF9 || d >= 12'hFFD) ? mem[d] : ind(s) ? 8'h00 : mem[s];
      send({9'h1D7, k[6:0]}, {4'hF, i[4:0], e[6:0]}, 1);
      @(posedge ref_clk);
      #1;
      chk(mem[d], x);
    end
    $display("test move done");
    for (i = 0; i < 4; i = i + 1)
    begin
      k = $urandom % 64;
      send({8'hE9, i[1:0], k[5:0]}, 16'h0000, 0);
      case (i)
        0: p0 = p0 - k;
        1: p1 = p1 - k;
        default: fp = fp - k;
      endcase
      chk(indirect_pointer0_q, p0);
      chk(indirect_pointer1_q, p1);
      chk(frame_pointer_q, fp);
    end
    $display("test subtract done");
    test_done;
  end
endmodule

// ==== verilog/sfx_addr_add.v ====
// Forms a frame-relative data address from a 7-bit offset.
// Assumes the frame pointer is the full 12-bit data address.
`timescale 1ns/1ps
module sfx_addr_add
(
  // Frame pointer and offset.
  input wire [11:0] base,
  input wire [6:0] offset,
  // Address, wrapping within the 4096-byte space.
  output wire [11:0] addr
);
  // Wrap at the top so any byte from 000h to FFFh is reachable.
  assign addr = base + {5'h00, offset};
endmodule

// ==== verilog/sfx_core.v ====
// Execution unit for the extended stack-frame instructions.
// Assumes one instruction word per clock from fetch and a data memory
// that reads combinationally and writes on the clock edge.
`timescale 1ns/1ps
`include "sfx_defs.vh"
// What this block does
// - Move addresses are frame pointer plus each word's 7-bit offset.
// - Move addresses may reach any byte from 000h to FFFh.
// - Move never writes program counter low or return-top bytes.
// - Move source on an indirect register reads as 00h.
// - Move destination on an indirect register suppresses the write.
// - Literal push writes the 8-bit literal at the frame pointer.
// - After pushing, the frame pointer decrements by one.
// - Pointer subtract decodes fixed high bits, 2-bit select, 6-bit literal.
// - Pointer subtract takes the literal from pointer 0, 1 or 2.
// - Subtract-and-return subtracts from frame pointer, loads PC from stack top.
// - Subtract-and-return takes two cycles; second cycle does nothing.
// - Select 11 means subtract-and-return, acting on the frame pointer only.
// - Extended set runs only when the extension enable bit is set.
module sfx_core
(
  // Clock and reset.
  input wire ref_clk,
  input wire resetn,
  // Decoded instruction word from fetch.
  input wire instr_valid,
  input wire [15:0] instr,
  // Configuration: extension enable, default zero.
  input wire extension_enable_bit,
  // Return stack top from the core.
  input wire [20:0] return_stack_top,
  // Data memory read port.
  output reg [11:0] mem_raddr_q,
  input wire [7:0] mem_rdata,
  // Data memory write port.
  output reg mem_we_q,
  output reg [11:0] mem_waddr_q,
  output reg [7:0] mem_wdata_q,
  // Pointer registers.
  output reg [11:0] indirect_pointer0_q,
  output reg [11:0] indirect_pointer1_q,
  output reg [11:0] frame_pointer_q,
  // Program counter load.
  output reg pc_load_q,
  output reg [20:0] pc_value_q,
  // Stall request: high during a second instruction cycle.
  output reg busy_q
);
  // Sequencer states; a move or a return keeps the unit for a second cycle.
  localparam ST_IDLE = 2'h0;
  localparam ST_MOVE2 = 2'h1;
  localparam ST_RET2 = 2'h2;

  // Sequencer state and its next value.
  reg [1:0] state_q;
  reg [1:0] state_d;
  // Next values of the registered outputs.
  reg [11:0] mem_raddr_d;
  reg mem_we_d;
  reg [11:0] mem_waddr_d;
  reg [7:0] mem_wdata_d;
  reg [11:0] indirect_pointer0_d;
  reg [11:0] indirect_pointer1_d;
  reg [11:0] frame_pointer_d;
  reg pc_load_d;
  reg [20:0] pc_value_d;
  reg busy_d;
  // Address arithmetic and window checks.
  wire [11:0] src_addr;
  wire [11:0] dst_addr;
  wire src_ind;
  wire dst_ind;
  wire dst_prot;
  wire [7:0] move_data;
  // Instruction decode.
  wire ext_ok;
  wire idle;
  wire is_move;
  wire is_push;
  wire is_sub;
  wire is_ret;
  wire second_ok;
  wire move_done;
  wire [1:0] sel;
  wire [11:0] lit6;

  // Nothing decodes unless the extension is enabled, and a pending second
  // cycle blocks decoding so that it cannot start a new operation.
  assign ext_ok = instr_valid && extension_enable_bit;
  assign idle = state_q == ST_IDLE;
  assign is_move = ext_ok && idle && instr[15:7] == `SFX_OP_MOVE_HI;
  assign is_push = ext_ok && idle && instr[15:8] == `SFX_OP_PUSH_HI;
  assign is_sub = ext_ok && idle && instr[15:8] == `SFX_OP_SUB_HI;

  // Select and literal fields of the pointer subtract.
  assign sel = instr[`SFX_SEL_MSB:`SFX_SEL_LSB];
  assign lit6 = {6'h00, instr[`SFX_LIT6_MSB:0]};
  assign is_ret = is_sub && sel == `SFX_SEL_FRAME;

  // The second move word is known by its fixed top nibble; until it comes,
  // the move waits rather than taking a stray word as its destination.
  assign second_ok = instr_valid && instr[15:12] == `SFX_OP_SECOND_HI;
  assign move_done = state_q == ST_MOVE2 && second_ok;

  // Source offset comes from the first word, destination from the second;
  // both adders see the word on the bus, so each is used in its own cycle.
  sfx_addr_add u_src_add
  (
    .base(frame_pointer_q),
    .offset(instr[`SFX_OFS_MSB:0]),
    .addr(src_addr)
  );

  sfx_addr_add u_dst_add
  (
    .base(frame_pointer_q),
    .offset(instr[`SFX_OFS_MSB:0]),
    .addr(dst_addr)
  );

  // The source is checked at the latched read address, since the word on
  // the bus in the second cycle carries the destination offset.
  sfx_ind_check u_src_ind
  (
    .addr(mem_raddr_q),
    .is_ind(src_ind)
  );

  sfx_ind_check u_dst_ind
  (
    .addr(dst_addr),
    .is_ind(dst_ind)
  );

  // Writes here would corrupt control flow, so they are refused.
  assign dst_prot = dst_addr == `SFX_ADDR_PCL || dst_addr == `SFX_ADDR_RETURN_TOP_LOW ||
                    dst_addr == `SFX_ADDR_RETURN_TOP_HIGH || dst_addr == `SFX_ADDR_RETURN_TOP_UPPER;

  // An indirect register never yields its contents as move data.
  assign move_data = src_ind ? `SFX_DATA_ZERO : mem_rdata;

  // Sequencer for the two-cycle instructions.
  always @*
  begin
    state_d = ST_IDLE;
    case (state_q)
      ST_IDLE:
      begin
        if (is_move)
          state_d = ST_MOVE2;
        else if (is_ret)
          state_d = ST_RET2;
      end
      ST_MOVE2:
      begin
        // A missing second word holds the move; fetch must supply it.
        if (!second_ok)
          state_d = ST_MOVE2;
      end
      ST_RET2:
        state_d = ST_IDLE;
      default:
        state_d = ST_IDLE;
    endcase
  end

  // Busy marks every cycle in which a second cycle is still pending.
  always @*
  begin
    busy_d = state_d != ST_IDLE;
  end

  // Read address: the source is latched with the first word, so its data
  // stands on the read port through the whole second cycle.
  always @*
  begin
    mem_raddr_d = mem_raddr_q;
    if (is_move)
      mem_raddr_d = src_addr;
  end

  // Write port: a move writes as its second word arrives, a push at once.
  // The two never meet, since a push is only decoded while idle.
  always @*
  begin
    mem_we_d = 1'b0;
    mem_waddr_d = mem_waddr_q;
    mem_wdata_d = mem_wdata_q;
    if (move_done)
    begin
      // Indirect or protected destinations leave memory untouched.
      mem_we_d = !dst_ind && !dst_prot;
      mem_waddr_d = dst_addr;
      mem_wdata_d = move_data;
    end
    else if (is_push)
    begin
      mem_we_d = 1'b1;
      mem_waddr_d = frame_pointer_q;
      mem_wdata_d = instr[7:0];
    end
  end

  // Pointer arithmetic wraps within the 12-bit data space; software that
  // underflows its stack lands at the top of memory without warning.
  always @*
  begin
    indirect_pointer0_d = indirect_pointer0_q;
    indirect_pointer1_d = indirect_pointer1_q;
    frame_pointer_d = frame_pointer_q;
    if (is_push)
      frame_pointer_d = frame_pointer_q - 12'h001;
    if (is_sub)
    begin
      case (sel)
        2'h0:
          indirect_pointer0_d = indirect_pointer0_q - lit6;
        2'h1:
          indirect_pointer1_d = indirect_pointer1_q - lit6;
        2'h2:
          frame_pointer_d = frame_pointer_q - lit6;
        default:
          frame_pointer_d = frame_pointer_q - lit6;
      endcase
    end
  end

  // Return: the program counter is loaded from the stack top in the first
  // cycle; the second cycle is the sequencer's idle step.
  always @*
  begin
    pc_load_d = is_ret;
    pc_value_d = pc_value_q;
    if (is_ret)
      pc_value_d = return_stack_top;
  end

  // Sequencer and stall flip-flops.
  always @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_q <= ST_IDLE;
      busy_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      busy_q <= busy_d;
    end
  end

  // Data memory port flip-flops.
  always @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      mem_raddr_q <= `SFX_PTR_RESET;
      mem_we_q <= 1'b0;
      mem_waddr_q <= `SFX_PTR_RESET;
      mem_wdata_q <= `SFX_DATA_ZERO;
    end
    else
    begin
      mem_raddr_q <= mem_raddr_d;
      mem_we_q <= mem_we_d;
      mem_waddr_q <= mem_waddr_d;
      mem_wdata_q <= mem_wdata_d;
    end
  end

  // Pointer flip-flops.
  always @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      indirect_pointer0_q <= `SFX_PTR_RESET;
      indirect_pointer1_q <= `SFX_PTR_RESET;
      frame_pointer_q <= `SFX_PTR_RESET;
    end
    else
    begin
      indirect_pointer0_q <= indirect_pointer0_d;
      indirect_pointer1_q <= indirect_pointer1_d;
      frame_pointer_q <= frame_pointer_d;
    end
  end

  // Program counter load flip-flops; the load is a one-cycle pulse.
  always @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pc_load_q <= 1'b0;
      pc_value_q <= `SFX_PC_RESET;
    end
    else
    begin
      pc_load_q <= pc_load_d;
      pc_value_q <= pc_value_d;
    end
  end
endmodule

// ==== verilog/sfx_defs.vh ====
// Constants for the stack frame extended operation unit.
// Assumes a 12-bit data address space and 16-bit instruction words.
`ifndef SFX_DEFS_VH
`define SFX_DEFS_VH
// Opcode prefixes.
`define SFX_OP_MOVE_HI 9'h1D7
`define SFX_OP_SECOND_HI 4'hF
`define SFX_OP_PUSH_HI 8'hFA
`define SFX_OP_SUB_HI 8'hE9
`define SFX_SEL_FRAME 2'h3
// Field positions.
`define SFX_OFS_MSB 6
`define SFX_LIT6_MSB 5
`define SFX_SEL_MSB 7
`define SFX_SEL_LSB 6
// Special data addresses: indirect registers and the protected bytes.
`define SFX_ADDR_IND1_LO 12'hFE7
`define SFX_ADDR_IND1_HI 12'hFE7
`define SFX_ADDR_IND2_LO 12'hFDF
`define SFX_ADDR_IND2_HI 12'hFDF
`define SFX_ADDR_IND0_LO 12'hFEF
`define SFX_ADDR_IND0_HI 12'hFEF
`define SFX_ADDR_PCL 12'hFF9
`define SFX_ADDR_RETURN_TOP_LOW 12'hFFD
`define SFX_ADDR_RETURN_TOP_HIGH 12'hFFE
`define SFX_ADDR_RETURN_TOP_UPPER 12'hFFF
// Indirect register windows: five per pointer, spaced eight bytes.
`define SFX_IND_SPAN 12'h004
`define SFX_IND_BASE0 12'hFEB
`define SFX_IND_BASE1 12'hFE3
`define SFX_IND_BASE2 12'hFDB
// Reset values.
`define SFX_PTR_RESET 12'h000
`define SFX_PC_RESET 21'h00000
`define SFX_DATA_ZERO 8'h00
`endif

// ==== verilog/sfx_ind_check.v ====
// Flags whether a data address falls on an indirect-addressing register.
// Assumes each pointer's window is five consecutive bytes from its base.
`timescale 1ns/1ps
`include "sfx_defs.vh"
module sfx_ind_check
(
  // Address under test.
  input wire [11:0] addr,
  // High when the address is an indirect register.
  output wire is_ind
);
  // The three windows are checked the same way.
  assign is_ind = (addr >= `SFX_IND_BASE0 && addr <= `SFX_IND_BASE0 + `SFX_IND_SPAN) ||
                  (addr >= `SFX_IND_BASE1 && addr <= `SFX_IND_BASE1 + `SFX_IND_SPAN) ||
                  (addr >= `SFX_IND_BASE2 && addr <= `SFX_IND_BASE2 + `SFX_IND_SPAN);
endmodule
